/* File: src/pgs_map.vh */
// Constants for the page program write sequencer host controller
`ifndef PGS_MAP_VH
`define PGS_MAP_VH
`define PGS_CLK_MHZ 50
`define PGS_PAGE_BYTES 64
`define PGS_PAGE_LSB 6
`define PGS_ADDR_W 15
`define PGS_DATA_W 8
`define PGS_T_WP_NS 90
`define PGS_T_WP_CYC ((`PGS_T_WP_NS * `PGS_CLK_MHZ + 999) / 1000)
`define PGS_T_WPH_NS 100
`define PGS_T_WPH_CYC ((`PGS_T_WPH_NS * `PGS_CLK_MHZ + 999) / 1000)
`define PGS_T_ACC_NS 150
`define PGS_T_ACC_CYC ((`PGS_T_ACC_NS * `PGS_CLK_MHZ + 999) / 1000)
`define PGS_T_OEHP_NS 150
`define PGS_T_OEHP_CYC ((`PGS_T_OEHP_NS * `PGS_CLK_MHZ + 999) / 1000)
`define PGS_T_BLC_US 150
`define PGS_T_BLC_CYC ((`PGS_T_BLC_US * `PGS_CLK_MHZ))
`define PGS_T_WC_MS 10
`define PGS_T_WC_CYC (`PGS_T_WC_MS * 1000 * `PGS_CLK_MHZ)
`define PGS_CMD_A1 15'h5555
`define PGS_CMD_A2 15'h2aaa
`define PGS_CMD_D1 8'haa
`define PGS_CMD_D2 8'h55
`define PGS_CMD_PROT_ON 8'ha0
`define PGS_CMD_PROT_OFF 8'h20
`define PGS_CMD_PROT_OFF3 8'h80
`define PGS_CMD_ID_IN 8'h90
`define PGS_CMD_ID_OUT 8'hf0
`define PGS_OP_READ 3'h0
`define PGS_OP_PAGE 3'h1
`define PGS_OP_PROT_ON 3'h2
`define PGS_OP_PROT_OFF 3'h3
`define PGS_OP_ID_IN 3'h4
`define PGS_OP_ID_OUT 3'h5
`endif

/* File: src/pgs_sync3.v */
// Three-stage input synchroniser; change accepted when stages two and three agree
`timescale 1ns/1ps
module pgs_sync3 #(
	parameter W = 8
) (
	input wire mclk,
	input wire rst,
	input wire [W-1:0] d,
	output reg [W-1:0] q
);
	reg [W-1:0] s1_r;
	reg [W-1:0] s2_r;
	reg [W-1:0] s3_r;
	integer i;

	// First stage feeds only the second
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			s1_r <= {W{1'b0}};
			s2_r <= {W{1'b0}};
			s3_r <= {W{1'b0}};
			q <= {W{1'b0}};
		end else begin
			s1_r <= d;
			s2_r <= s1_r;
			s3_r <= s2_r;
			for (i = 0; i < W; i = i + 1) begin
				if (s2_r[i] == s3_r[i]) begin
					q[i] <= s3_r[i];
				end
			end
		end
	end
endmodule

/* File: src/pgs_host.v */
// Host controller driving a parallel page-program flash through its pins
`timescale 1ns/1ps
`include "pgs_map.vh"
module pgs_host #(
	parameter ADDR_W = `PGS_ADDR_W,
	parameter DATA_W = `PGS_DATA_W,
	parameter PAGE_BYTES = `PGS_PAGE_BYTES,
	parameter WC_CYC = `PGS_T_WC_CYC,
	parameter BLC_CYC = `PGS_T_BLC_CYC
) (
	input wire mclk,
	input wire rst,
	input wire cmd_valid,
	input wire [2:0] cmd_op,
	input wire [ADDR_W-1:0] cmd_addr,
	input wire [DATA_W-1:0] cmd_wdata,
	output reg cmd_ready,
	output reg wdata_req,
	output reg [5:0] wdata_idx,
	output reg rsp_valid,
	output reg [DATA_W-1:0] rsp_rdata,
	output reg rsp_timeout,
	output reg [ADDR_W-1:0] flash_addr,
	output reg [DATA_W-1:0] flash_dq_o,
	output reg flash_dq_oe,
	input wire [DATA_W-1:0] flash_dq_i,
	output reg chip_select_n,
	output reg output_gate_n,
	output reg write_strobe_n
);
	localparam [7:0] S_IDLE = 8'h01;
	localparam [7:0] S_WLOW = 8'h02;
	localparam [7:0] S_WHIGH = 8'h04;
	localparam [7:0] S_RLOW = 8'h08;
	localparam [7:0] S_RHIGH = 8'h10;
	localparam [7:0] S_POLL = 8'h20;
	localparam [7:0] S_DONE = 8'h40;
	localparam [7:0] S_WAITD = 8'h80;
	localparam [23:0] WP_CYC = `PGS_T_WP_CYC;
	localparam [23:0] WPH_CYC = `PGS_T_WPH_CYC;
	localparam [23:0] ACC_CYC = `PGS_T_ACC_CYC;
	localparam [23:0] OEHP_CYC = `PGS_T_OEHP_CYC;

	reg [7:0] state_r;
	reg [2:0] op_r;
	reg [ADDR_W-1:0] base_r;
	reg [2:0] step_r;
	reg [6:0] byte_r;
	reg [23:0] tmr_r;
	reg [23:0] wc_r;
	reg polling_r;
	reg have_prev_r;
	reg prev6_r;
	reg seen_r;
	wire [DATA_W-1:0] dq_s;

	// Data lines come from the other party, so synchronise them
	pgs_sync3 #(.W(DATA_W)) u_sync (
		.mclk(mclk),
		.rst(rst),
		.d(flash_dq_i),
		.q(dq_s)
	);

	// Number of unlock steps before data for each operation
	function [2:0] pre_len;
		input [2:0] op;
		begin
			case (op)
				`PGS_OP_PROT_ON: pre_len = 3'h3;
				`PGS_OP_PROT_OFF: pre_len = 3'h6;
				`PGS_OP_ID_IN: pre_len = 3'h3;
				`PGS_OP_ID_OUT: pre_len = 3'h3;
				default: pre_len = 3'h0;
			endcase
		end
	endfunction

	// Address of unlock step; steps one and four use the second command address
	function [ADDR_W-1:0] pre_addr;
		input [2:0] s;
		begin
			pre_addr = (s == 3'h1 || s == 3'h4) ? `PGS_CMD_A2 : `PGS_CMD_A1;
		end
	endfunction

	// Data of unlock step for the operation
	function [DATA_W-1:0] pre_data;
		input [2:0] op;
		input [2:0] s;
		begin
			case (s)
				3'h0, 3'h3: pre_data = `PGS_CMD_D1;
				3'h1, 3'h4: pre_data = `PGS_CMD_D2;
				default: begin
					case (op)
						`PGS_OP_PROT_ON: pre_data = `PGS_CMD_PROT_ON;
						`PGS_OP_ID_IN: pre_data = `PGS_CMD_ID_IN;
						`PGS_OP_ID_OUT: pre_data = `PGS_CMD_ID_OUT;
						default: pre_data = (s == 3'h2) ? `PGS_CMD_PROT_OFF3 : `PGS_CMD_PROT_OFF;
					endcase
				end
			endcase
		end
	endfunction

	wire in_pre = (step_r < pre_len(op_r));
	wire has_page = (op_r == `PGS_OP_PAGE) || (op_r == `PGS_OP_PROT_ON) || (op_r == `PGS_OP_PROT_OFF);

	// Main sequencer; write and read strobes on chip select plus one strobe line
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_r <= S_IDLE;
			op_r <= 3'h0;
			base_r <= {ADDR_W{1'b0}};
			step_r <= 3'h0;
			byte_r <= 7'h00;
			tmr_r <= 24'h000000;
			wc_r <= 24'h000000;
			polling_r <= 1'b0;
			have_prev_r <= 1'b0;
			prev6_r <= 1'b0;
			seen_r <= 1'b0;
			cmd_ready <= 1'b1;
			wdata_req <= 1'b0;
			wdata_idx <= 6'h00;
			rsp_valid <= 1'b0;
			rsp_rdata <= {DATA_W{1'b0}};
			rsp_timeout <= 1'b0;
			flash_addr <= {ADDR_W{1'b0}};
			flash_dq_o <= {DATA_W{1'b0}};
			flash_dq_oe <= 1'b0;
			chip_select_n <= 1'b1;
			output_gate_n <= 1'b1;
			write_strobe_n <= 1'b1;
		end else begin
			rsp_valid <= 1'b0;
			wdata_req <= 1'b0;
			if (polling_r) begin
				wc_r <= wc_r + 24'h000001;
			end
			case (state_r)
				S_IDLE: begin
					if (cmd_valid) begin
						cmd_ready <= 1'b0;
						op_r <= cmd_op;
						base_r <= cmd_addr;
						step_r <= 3'h0;
						byte_r <= 7'h00;
						rsp_timeout <= 1'b0;
						tmr_r <= 24'h000000;
						if (cmd_op == `PGS_OP_READ) begin
							flash_addr <= cmd_addr;
							state_r <= S_RLOW;
						end else if (cmd_op > `PGS_OP_ID_OUT) begin
							// Unknown codes finish at once so no stray write reaches the pins
							state_r <= S_DONE;
						end else begin
							state_r <= S_WAITD;
						end
					end
				end
				S_WAITD: begin
					if (in_pre) begin
						flash_addr <= pre_addr(step_r);
						flash_dq_o <= pre_data(op_r, step_r);
					end else begin
						flash_addr <= {base_r[ADDR_W-1:`PGS_PAGE_LSB], byte_r[5:0]};
						flash_dq_o <= cmd_wdata;
						wdata_idx <= byte_r[5:0];
						wdata_req <= 1'b1;
					end
					flash_dq_oe <= 1'b1;
					output_gate_n <= 1'b1;
					tmr_r <= 24'h000000;
					state_r <= S_WLOW;
				end
				S_WLOW: begin
					chip_select_n <= 1'b0;
					write_strobe_n <= 1'b0;
					tmr_r <= tmr_r + 24'h000001;
					if (tmr_r >= WP_CYC) begin
						write_strobe_n <= 1'b1;
						chip_select_n <= 1'b1;
						tmr_r <= 24'h000000;
						state_r <= S_WHIGH;
					end
				end
				S_WHIGH: begin
					tmr_r <= tmr_r + 24'h000001;
					if (tmr_r >= WPH_CYC) begin
						tmr_r <= 24'h000000;
						if (in_pre) begin
							step_r <= step_r + 3'h1;
							state_r <= (step_r + 3'h1 < pre_len(op_r) || has_page) ? S_WAITD : S_DONE;
						end else if (has_page && byte_r < PAGE_BYTES - 1) begin
							byte_r <= byte_r + 7'h01;
							state_r <= S_WAITD;
						end else if (has_page) begin
							flash_dq_oe <= 1'b0;
							flash_addr <= {base_r[ADDR_W-1:`PGS_PAGE_LSB], 6'h3f};
							polling_r <= 1'b1;
							wc_r <= 24'h000000;
							have_prev_r <= 1'b0;
							seen_r <= 1'b0;
							state_r <= S_POLL;
						end else begin
							state_r <= S_DONE;
						end
					end
				end
				S_RLOW: begin
					flash_dq_oe <= 1'b0;
					chip_select_n <= 1'b0;
					output_gate_n <= 1'b0;
					tmr_r <= tmr_r + 24'h000001;
					if (tmr_r >= ACC_CYC + 24'h000003) begin
						chip_select_n <= 1'b1;
						output_gate_n <= 1'b1;
						tmr_r <= 24'h000000;
						state_r <= polling_r ? S_POLL : S_DONE;
						seen_r <= polling_r;
						rsp_rdata <= dq_s;
					end
				end
				S_POLL: begin
					tmr_r <= tmr_r + 24'h000001;
					if (wc_r < BLC_CYC) begin
						tmr_r <= 24'h000000; // Reads before the cycle starts would match and end polling early
					end else if (tmr_r >= OEHP_CYC) begin
						tmr_r <= 24'h000000;
						have_prev_r <= seen_r;
						prev6_r <= rsp_rdata[6];
						if (have_prev_r && seen_r && prev6_r == rsp_rdata[6]) begin
							polling_r <= 1'b0;
							state_r <= S_DONE;
						end else if (wc_r >= WC_CYC + BLC_CYC) begin
							polling_r <= 1'b0;
							rsp_timeout <= 1'b1;
							state_r <= S_DONE;
						end else begin
							state_r <= S_RLOW;
						end
					end
				end
				S_DONE: begin
					flash_dq_oe <= 1'b0;
					rsp_valid <= 1'b1;
					cmd_ready <= 1'b1;
					state_r <= S_IDLE;
				end
				default: begin
					state_r <= S_IDLE;
				end
			endcase
		end
	end
endmodule

/* File: dv/pgs_host_properties.sv */
// Pin protocol assertions for the flash host controller
`timescale 1ns/1ps
module pgs_host_chk #(
	parameter BLC_CYC = 7500
) (
	input wire mclk,
	input wire rst,
	input wire cmd_valid,
	input wire [14:0] cmd_addr,
	input wire cmd_ready,
	input wire [5:0] wdata_idx,
	input wire [14:0] flash_addr,
	input wire flash_dq_oe,
	input wire chip_select_n,
	input wire output_gate_n,
	input wire write_strobe_n
);
	reg [8:0] pg_r;
	reg wn_r;
	integer gap_r;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// Page taken with the command; cycles since the last write fall
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			pg_r <= 9'h000;
			wn_r <= 1'b1;
			gap_r <= 0;
		end else begin
			wn_r <= write_strobe_n;
			gap_r <= (wn_r && !write_strobe_n) ? 0 : gap_r + 1;
			if (cmd_valid && cmd_ready) pg_r <= cmd_addr[14:6];
		end
	end
	a_gate_off_write: assert property (!write_strobe_n && !chip_select_n |-> output_gate_n)
		else $error("gate low in write");
	a_no_drive_read: assert property (!output_gate_n |-> !flash_dq_oe)
		else $error("drive during read");
	a_page_addr_ok: assert property ($fell(write_strobe_n) && flash_addr != 15'h5555 && flash_addr != 15'h2aaa
		|-> flash_addr == {pg_r, wdata_idx}) else $error("bad page address");
	a_load_window: assert property ($fell(write_strobe_n) && wdata_idx != 6'h00 && flash_addr != 15'h5555
		&& flash_addr != 15'h2aaa |-> gap_r < BLC_CYC) else $error("load window exceeded");
	a_read_addr_hold: assert property (!output_gate_n && !$past(output_gate_n) |-> $stable(flash_addr))
		else $error("address moved in read");
	a_data_on_write: assert property (!write_strobe_n |-> flash_dq_oe)
		else $error("data not driven");
	a_write_width: assert property ($fell(write_strobe_n) |-> !write_strobe_n [*5])
		else $error("short write pulse");
	a_take_busy: assert property (cmd_valid && cmd_ready |=> !cmd_ready)
		else $error("ready after take");
endmodule
bind pgs_host pgs_host_chk #(.BLC_CYC(BLC_CYC)) chk_u (.*);

/* File: dv/pgs_flash_mdl.sv */
// Behavioural page flash with protection, status bits and identification
`timescale 1ns/1ps
module pgs_flash_mdl #(
	parameter BLC = 40,
	parameter WC = 150,
	parameter MFR = 8'h3c,
	parameter DEV = 8'ha5
) (
	input wire mclk,
	input wire [14:0] a,
	input wire [7:0] d,
	input wire cs_n,
	input wire oe_n,
	input wire we_n,
	output reg [7:0] q = 8'h00
);
	reg [7:0] mem [0:32767];
	reg [7:0] pb [0:63];
	reg [63:0] lm = 0;
	reg [14:0] la;
	reg [8:0] pa;
	reg [7:0] ld, lb;
	reg idm = 0;
	reg prot = 0, tg = 0, off = 0;
	integer st = 0, pend = 0, tmr = -1, busy = 0, i;
	wire wr = we_n | cs_n;
	initial for (i = 0; i < 32768; i++) mem[i] = 8'hff;
	// Capture pins while the write is low, avoiding the release race
	always @(posedge mclk) if (!wr) begin
		la <= a;
		ld <= d;
	end
	always @(posedge wr) if (busy == 0 && oe_n) begin
		if (st == 0 && la == 15'h5555 && ld == 8'haa) st = 1;
		else if (st == 1 && la == 15'h2aaa && ld == 8'h55) st = 2;
		else if (st == 2 && la == 15'h5555) begin
			st = 0;
			idm = ld == 8'h90 ? 1 : ld == 8'hf0 ? 0 : idm;
			pend = ld == 8'ha0 ? 1 : (ld == 8'h20 && off) ? 2 : pend;
			off = ld == 8'h80;
		end else begin
			st = 0;
			if (!prot || pend != 0) begin
				pb[la[5:0]] = ld;
				lm[la[5:0]] = 1;
				pa = la[14:6];
				lb = ld;
				tmr = 0;
			end
		end
	end
	always @(posedge mclk) begin
		if (tmr >= 0) tmr = tmr + 1;
		if (tmr == BLC) begin
			tmr = -1;
			busy = WC;
		end else if (busy > 0) begin
			busy = busy - 1;
			if (busy == 0) begin
				for (i = 0; i < 64; i++) mem[{pa, i[5:0]}] = lm[i] ? pb[i] : 8'($urandom);
				lm = 0;
				prot = pend == 1 ? 1 : pend == 2 ? 0 : prot;
				pend = 0;
			end
		end
	end
	always @(negedge (cs_n | oe_n)) if (busy > 0) tg = ~tg;
	// Read data; a released bus shows a changing pattern
	always @(cs_n, oe_n, a, busy, tg, idm) begin
		if (cs_n || oe_n) q = ~q;
		else if (busy > 0) q = {~lb[7], tg, 6'h00};
		else if (idm && a[14:1] == 0) q = a[0] ? DEV : MFR;
		else q = mem[a];
	end
endmodule

/* File: dv/tb.sv */
// Self-checking bench for the flash host controller
`timescale 1ns/1ps
module tb;
	localparam [7:0] MFR = 8'h3c, DEV = 8'ha5; // Arbitrary identity values
	reg mclk = 0, rst = 1, cmd_valid = 0, prot_e = 0;
	reg [2:0] cmd_op = 0;
	reg [14:0] cmd_addr = 0;
	reg [7:0] cmd_wdata = 0;
	reg [8:0] p;
	reg [7:0] pd [0:63];
	int exp [int];
	int mismatches = 0, comparisons = 0, cyc = 0, i, nb = 0;
	wire rdy, rv, rto, oe, csn, ogn, wsn, wreq;
	wire [5:0] idx;
	wire [7:0] rdat, dqo, dqi;
	wire [14:0] fa;
	initial forever #10 mclk = ~mclk;
	pgs_host #(.WC_CYC(200), .BLC_CYC(50)) dut_u (.mclk(mclk), .rst(rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
		.cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(rdy), .wdata_req(wreq), .wdata_idx(idx), .rsp_valid(rv),
		.rsp_rdata(rdat), .rsp_timeout(rto), .flash_addr(fa), .flash_dq_o(dqo), .flash_dq_oe(oe), .flash_dq_i(dqi),
		.chip_select_n(csn), .output_gate_n(ogn), .write_strobe_n(wsn));
	pgs_flash_mdl #(.MFR(MFR), .DEV(DEV)) fl_u (.mclk(mclk), .a(fa), .d(dqo), .cs_n(csn), .oe_n(ogn), .we_n(wsn), .q(dqi));
	// Byte the sequencer takes next; it samples the data in the cycle that announces the index
	always @(negedge mclk) begin
		if (rdy) nb = 0;
		else if (wreq) begin
			chk({2'h0, idx}, nb[7:0]);
			nb = nb + 1;
		end
		cmd_wdata <= pd[nb[5:0]];
	end
	// Hang guard, well above the expected run length
	always @(posedge mclk) if (++cyc == 30000) begin
		mismatches++;
		tally_and_finish;
	end
	task automatic chk(input [7:0] got, input [7:0] want);
		comparisons++;
		if (got !== want) begin
			mismatches++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, want);
		end
	endtask
	task automatic op(input [2:0] o, input [14:0] a);
		while (rdy !== 1'b1) @(negedge mclk);
		cmd_op = o;
		cmd_addr = a;
		cmd_valid = 1;
		@(negedge mclk);
		cmd_valid = 0;
		while (rv !== 1'b1) @(negedge mclk);
	endtask
	task automatic rd(input [14:0] a, input [7:0] w);
		op(0, a);
		chk(rdat, w);
	endtask
	// Page with random data, then full read-back against the reference
	task automatic pg(input [2:0] o);
		for (i = 0; i < 64; i++) pd[i] = 8'($urandom);
		op(o, {p, 6'h00});
		chk({7'h0, rto}, 8'h00);
		if (o != 1 || !prot_e) for (i = 0; i < 64; i++) exp[{p, i[5:0]}] = pd[i];
		prot_e = o == 2 ? 1 : o == 3 ? 0 : prot_e;
		for (i = 0; i < 64; i++) rd({p, i[5:0]}, 8'(exp[{p, i[5:0]}]));
	endtask
	task tally_and_finish;
		$display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		void'($urandom(48));
		repeat (2) @(negedge mclk);
		rst = 0;
		chk({3'h0, rdy, csn, ogn, wsn, oe}, 8'h1e);
		rd(15'h7000 | 15'($urandom % 4096), 8'hff);
		p = 9'($urandom % 64 + 1);
		pg(1);
		pg(2);
		pg(1);
		pg(3);
		pg(1);
		op(4, 15'h0000);
		rd(15'h0000, MFR);
		rd(15'h0001, DEV);
		op(5, 15'h0000);
		rd(15'h0000, 8'hff);
		op(7, 15'h0000);
		// An unknown code must not write; give a stray program cycle time to land
		repeat (300) @(negedge mclk);
		rd(15'h0000, 8'hff);
		rd(15'h7fff, 8'hff);
		tally_and_finish;
	end
endmodule
